// File: rtl/i2c_slave_rx.sv
// Two-wire slave receiver: conditions, address match, acknowledge, stretch
`include "i2c_slave_params.svh"
module i2c_slave_rx
	import i2c_slave_pkg::*;
#(
	parameter int FILTER_CYC = `GLITCH_CYC
) (
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_out,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	input  wire ctrl_s      ctrl_in,
	input  wire sw_s        sw_in,
	input  wire logic [7:0] address_in,
	output status_s         status_out,
	output logic [7:0]      receive_buffer_out
);
	if (FILTER_CYC < 1 || FILTER_CYC > 3) begin : g_check
		$error("i2c_slave_rx: filter too long for the bus bit time");
	end

	slave_state_e state_q;
	logic       scl_f, sda_f, scl_p_q, sda_p_q, low_seen_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q, addr_q;
	logic       ack_phase_q, hold_q, auto_q, acc_q, rw_q, prior_q;
	logic       ack_drive_q, ckp_q, irq_q, full_q, ovf_q, ua_q;
	logic       ack_rcv_q, ack_time_q, start_seen_q, stop_seen_q, dna_q;
	logic       scl_rise, scl_fall, start_det, stop_det, rise_bit, fall8, fall9;
	logic       ten, ss_irq, hi_match, lo_match, matched, is_addr, hold, auto_ack;
	logic       load_buf, acked, stretch_8, stretch_9, ua_set, set_irq;

	line_filter #(.STABLE_CYC(FILTER_CYC)) u_scl_filter (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.line_in  (scl_in),
		.level_out(scl_f)
	);
	line_filter #(.STABLE_CYC(FILTER_CYC)) u_sda_filter (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.line_in  (sda_in),
		.level_out(sda_f)
	);

	assign scl_rise  = scl_f & ~scl_p_q;
	assign scl_fall  = ~scl_f & scl_p_q;
	assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
	// A data bounce with the clock never low stays a plain start
	assign stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f & low_seen_q;
	assign rise_bit  = scl_rise & ~ack_phase_q & (bit_cnt_q < `BYTE_BITS) & (state_q != st_idle);
	assign fall8     = scl_fall & ~ack_phase_q & (bit_cnt_q == `BYTE_BITS) & (state_q != st_idle);
	assign fall9     = scl_fall & ack_phase_q;

	assign ten      = ctrl_in.port_mode_field[`MODE_TEN_BIT_POS];
	assign ss_irq   = ctrl_in.port_mode_field[`MODE_SS_IRQ_POS];
	assign hi_match = ten ? ((shift_q[7:3] == `TEN_BIT_HI_TAG) && (shift_q[2:1] == addr_q[2:1])
		&& (!shift_q[0] || prior_q))
		: (shift_q[7:1] == addr_q[7:1]);
	assign lo_match = (shift_q == addr_q);
	assign matched  = (state_q == st_data) | ((state_q == st_addr_hi) & hi_match)
		| ((state_q == st_addr_lo) & lo_match);
	assign is_addr  = (state_q != st_data);
	assign hold     = is_addr ? ctrl_in.address_hold_enable : ctrl_in.data_hold_enable;
	assign auto_ack = matched & ~((full_q | ovf_q) & ~ctrl_in.buffer_overwrite_enable);
	assign load_buf = fall8 & matched & (~full_q | ctrl_in.buffer_overwrite_enable);
	assign acked    = ~ack_rcv_q;
	assign stretch_8 = fall8 & matched & hold;
	assign stretch_9 = fall9 & acked & acc_q
		& (ctrl_in.stretch_enable | (rw_q & (state_q == st_addr_hi)));
	assign ua_set   = fall9 & ten & (((state_q == st_addr_hi) & acked & acc_q & ~rw_q)
		| (state_q == st_addr_lo));
	assign set_irq  = (start_det & (ss_irq | ctrl_in.start_irq_enable))
		| (stop_det & (ss_irq | ctrl_in.stop_irq_enable))
		| stretch_8
		| (fall9 & ((acked & acc_q) | (state_q == st_addr_lo)));

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			scl_p_q    <= `LINE_IDLE;
			sda_p_q    <= `LINE_IDLE;
			low_seen_q <= 1'b0;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
			if (start_det) begin
				low_seen_q <= 1'b0;
			end else if (scl_fall) begin
				low_seen_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			state_q     <= st_idle;
			bit_cnt_q   <= '0;
			ack_phase_q <= 1'b0;
			shift_q     <= '0;
			hold_q      <= 1'b0;
			auto_q      <= 1'b0;
			acc_q       <= 1'b0;
			rw_q        <= 1'b0;
			prior_q     <= 1'b0;
		end else if (start_det) begin
			state_q     <= st_addr_hi;
			bit_cnt_q   <= '0;
			ack_phase_q <= 1'b0;
		end else if (stop_det) begin
			state_q     <= st_idle;
			bit_cnt_q   <= '0;
			ack_phase_q <= 1'b0;
			prior_q     <= 1'b0;
		end else if (rise_bit) begin
			shift_q   <= {shift_q[6:0], sda_f};
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end else if (fall8) begin
			if (!matched) begin
				if (state_q == st_addr_hi) begin
					state_q <= st_idle;
					prior_q <= 1'b0;
				end else begin
					ack_phase_q <= 1'b1;
					acc_q       <= 1'b0;
					hold_q      <= hold;
					auto_q      <= 1'b0;
				end
			end else begin
				ack_phase_q <= 1'b1;
				acc_q       <= 1'b1;
				hold_q      <= hold;
				auto_q      <= auto_ack;
				if (state_q == st_addr_hi) begin
					rw_q <= shift_q[0];
					if (ten && !shift_q[0]) begin
						prior_q <= 1'b0;
					end
				end
				if (state_q == st_addr_lo) begin
					prior_q <= 1'b1;
				end
			end
		end else if (fall9) begin
			ack_phase_q <= 1'b0;
			bit_cnt_q   <= '0;
			unique case (state_q)
				st_addr_hi: state_q <= (!acked || !acc_q || rw_q) ? st_idle
					: (ten ? st_addr_lo : st_data);
				st_addr_lo: state_q <= (acked && acc_q) ? st_data : st_idle;
				st_data:    state_q <= acked ? st_data : st_idle;
				st_idle:    state_q <= st_idle;
			endcase
		end
	end

	// Drive starts two cycles after the eighth fall, while the clock is low
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ack_drive_q <= 1'b0;
		end else begin
			ack_drive_q <= ack_phase_q & ~fall9 & ~start_det & ~stop_det
				& (hold_q ? (acc_q & ~ctrl_in.ack_value_select) : auto_q);
		end
	end

	// Hardware stretch wins over a release pulse in the same cycle
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ckp_q <= 1'b1;
		end else if (start_det || stop_det) begin
			ckp_q <= 1'b1;
		end else if (stretch_8 || stretch_9) begin
			ckp_q <= 1'b0;
		end else if (sw_in.clock_release_set) begin
			ckp_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			irq_q <= 1'b0;
			full_q <= 1'b0;
			ovf_q <= 1'b0;
			ua_q <= 1'b0;
		end else begin
			irq_q  <= set_irq | (irq_q & ~sw_in.irq_clear);
			full_q <= load_buf | (full_q & ~sw_in.buffer_read);
			ovf_q  <= (fall8 & matched & full_q) | (ovf_q & ~sw_in.overflow_clear);
			ua_q   <= ua_set | (ua_q & ~sw_in.address_write);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			addr_q             <= `RESET_ADDR;
			receive_buffer_out <= `RESET_BUF;
			dna_q              <= 1'b0;
		end else begin
			if (sw_in.address_write) begin
				addr_q <= address_in;
			end
			if (load_buf) begin
				receive_buffer_out <= shift_q;
				dna_q              <= (state_q == st_data);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ack_rcv_q    <= 1'b1;
			ack_time_q   <= 1'b0;
			start_seen_q <= 1'b0;
			stop_seen_q  <= 1'b0;
		end else begin
			if (scl_rise && ack_phase_q) begin
				ack_rcv_q <= sda_f;
			end
			if (start_det || stop_det || fall9) begin
				ack_time_q <= 1'b0;
			end else if (fall8 && matched
				&& (ctrl_in.address_hold_enable || ctrl_in.data_hold_enable)) begin
				ack_time_q <= 1'b1;
			end
			if (start_det) begin
				start_seen_q <= 1'b1;
				stop_seen_q  <= 1'b0;
			end else if (stop_det) begin
				start_seen_q <= 1'b0;
				stop_seen_q  <= 1'b1;
			end
		end
	end

	// Open drain: only the enables move, the driven level is always low
	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign scl_oe_out = ~ckp_q | ua_q;
	assign sda_oe_out = ack_drive_q;
	assign status_out = '{start_seen: start_seen_q, stop_seen: stop_seen_q,
		read_not_write: rw_q, data_not_address: dna_q, ack_received_status: ack_rcv_q,
		ack_time_status: ack_time_q, address_refresh_needed: ua_q, buffer_full_flag: full_q,
		receive_overflow_flag: ovf_q, clock_release: ckp_q, port_irq_flag: irq_q};

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_start_flag;
		start_det |=> start_seen_q && !stop_seen_q;
	endproperty
	a_start_flag: assert property (p_start_flag) else $error("start bit not set");
	property p_ss_irq;
		start_det && ss_irq |=> irq_q;
	endproperty
	a_ss_irq: assert property (p_ss_irq) else $error("no irq on start");
	property p_stop_irq_en;
		stop_det && ctrl_in.stop_irq_enable |=> irq_q;
	endproperty
	a_stop_irq_en: assert property (p_stop_irq_en) else $error("no irq on stop");
	property p_release;
		sda_oe_out |-> $past(ack_phase_q);
	endproperty
	a_release: assert property (p_release) else $error("data driven outside ack");
	property p_auto_ack;
		fall8 && state_q == st_data && !ctrl_in.data_hold_enable && !full_q && !ovf_q
			|-> ##2 sda_oe_out;
	endproperty
	a_auto_ack: assert property (p_auto_ack) else $error("missing auto ack");
	property p_nack_full;
		fall8 && state_q == st_data && (full_q || ovf_q) && !ctrl_in.buffer_overwrite_enable
			&& !ctrl_in.data_hold_enable |-> ##2 !sda_oe_out;
	endproperty
	a_nack_full: assert property (p_nack_full) else $error("ack while full");
	property p_hold_ack;
		ack_phase_q && hold_q && acc_q && !fall9 && !ctrl_in.ack_value_select |=> sda_oe_out;
	endproperty
	a_hold_ack: assert property (p_hold_ack) else $error("chosen ack not driven");
	property p_ack_time_status;
		fall8 && matched && ctrl_in.address_hold_enable |=> ack_time_q;
	endproperty
	a_ack_time_status: assert property (p_ack_time_status) else $error("ack time not set");
	property p_mismatch;
		fall8 && state_q == st_addr_hi && !matched |=> state_q == st_idle && !$rose(irq_q);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch not silent");
	property p_ack_sample;
		scl_rise && ack_phase_q |=> ack_rcv_q == $past(sda_f);
	endproperty
	a_ack_sample: assert property (p_ack_sample) else $error("ack not sampled");
	property p_ua_clear;
		sw_in.address_write && !ua_set |=> !ua_q;
	endproperty
	a_ua_clear: assert property (p_ua_clear) else $error("refresh flag kept");
	property p_ten_low;
		fall9 && state_q == st_addr_lo |=> irq_q && ua_q && scl_oe_out;
	endproperty
	a_ten_low: assert property (p_ten_low) else $error("low byte not held");
	property p_stretch;
		fall9 && state_q == st_data && acked && ctrl_in.stretch_enable |=> scl_oe_out;
	endproperty
	a_stretch: assert property (p_stretch) else $error("no stretch");

	c_data_byte: cover property (fall9 && state_q == st_data && acked);
	c_ten_match: cover property (fall9 && state_q == st_addr_lo && acc_q);
	c_stop: cover property (stop_det);
endmodule

// File: shared/i2c_slave_params.svh
// Constants for the two-wire slave receiver: timing, field positions, reset values
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

`define CLK_MHZ          40
`define GLITCH_NS        50
`define GLITCH_CYC_RAW   ((`GLITCH_NS * `CLK_MHZ) / 1000)
`define GLITCH_CYC       ((`GLITCH_CYC_RAW < 1) ? 1 : `GLITCH_CYC_RAW)
`define MODE_TEN_BIT_POS 0
`define MODE_SS_IRQ_POS  1
`define TEN_BIT_HI_TAG   5'h1e
`define BYTE_BITS        4'h8
`define RESET_BUF        8'h00
`define RESET_ADDR       8'h00
`define LINE_IDLE        1'b1

`endif

// File: shared/i2c_slave_pkg.sv
// Types shared by the two-wire slave receiver
package i2c_slave_pkg;

	typedef enum logic [1:0] {st_idle, st_addr_hi, st_addr_lo, st_data} slave_state_e;

	typedef struct packed {
		logic [1:0] port_mode_field;
		logic       start_irq_enable;
		logic       stop_irq_enable;
		logic       address_hold_enable;
		logic       data_hold_enable;
		logic       ack_value_select;
		logic       buffer_overwrite_enable;
		logic       stretch_enable;
	} ctrl_s;

	typedef struct packed {
		logic irq_clear;
		logic buffer_read;
		logic overflow_clear;
		logic clock_release_set;
		logic address_write;
	} sw_s;

	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic read_not_write;
		logic data_not_address;
		logic ack_received_status;
		logic ack_time_status;
		logic address_refresh_needed;
		logic buffer_full_flag;
		logic receive_overflow_flag;
		logic clock_release;
		logic port_irq_flag;
	} status_s;

endpackage

// File: rtl/line_filter.sv
// Two-stage synchroniser and glitch filter for one bus line
`include "i2c_slave_params.svh"
module line_filter #(
	parameter int STABLE_CYC = `GLITCH_CYC
) (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic line_in,
	output logic      level_out
);
	localparam int CW = $clog2(STABLE_CYC + 1);

	if (STABLE_CYC < 1 || STABLE_CYC > 255) begin : g_check
		$error("line_filter: STABLE_CYC out of range");
	end

	logic          sync1_q;
	logic          sync2_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sync1_q <= `LINE_IDLE;
			sync2_q <= `LINE_IDLE;
		end else begin
			sync1_q <= line_in;
			sync2_q <= sync1_q;
		end
	end

	// Level moves only after STABLE_CYC equal samples, so spikes vanish
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			level_out <= `LINE_IDLE;
			cnt_q     <= '0;
		end else if (sync2_q == level_out) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
			level_out <= sync2_q;
			cnt_q     <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end
endmodule

// File: verif/bus_master.sv
// Behavioural two-wire bus master facing the slave receiver
module bus_master (
	input  wire logic clk_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_pull_out,
	output logic      sda_pull_out
);
	timeunit 1ns;
	timeprecision 1ps;

	int stuck = 0;

	initial begin
		scl_pull_out = 1'b0;
		sda_pull_out = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// Slave may stretch; wait is bounded so a stuck line is counted, not hung
	task automatic rise();
		int n;
		n = 0;
		scl_pull_out <= 1'b0;
		@(posedge clk_in);
		while (!scl_in && n < 3000) begin
			@(posedge clk_in);
			n++;
		end
		if (!scl_in) stuck++;
		wt(4);
	endtask

	// Low phase outlasts the slave's sync and filter delay on both lines
	task automatic put_bit(input logic b);
		wt(3);
		sda_pull_out <= ~b;
		wt(3);
		rise();
		scl_pull_out <= 1'b1;
	endtask

	// Long gap lets the slave drop its acknowledge before clock rises
	task automatic start_c();
		wt(2);
		sda_pull_out <= 1'b0;
		wt(6);
		rise();
		sda_pull_out <= 1'b1;
		wt(4);
		scl_pull_out <= 1'b1;
	endtask

	task automatic stop_c();
		wt(2);
		sda_pull_out <= 1'b1;
		wt(2);
		rise();
		sda_pull_out <= 1'b0;
		wt(4);
	endtask

	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) put_bit(b[i]);
		wt(2);
		sda_pull_out <= 1'b0;
		wt(6);
		rise();
		ack = ~sda_in;
		scl_pull_out <= 1'b1;
	endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for the two-wire slave receiver
module tb
	import i2c_slave_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [8:0] cfg;
		logic [7:0] a, b, bv;
		logic       ack, irq, rnw, refr;
	} row_s;

	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	ctrl_s      ctl = '0;
	sw_s        sw = '0;
	logic [7:0] adr = 8'h00;
	wire        scl_w;
	wire        sda_w;
	logic       m_scl, m_sda, s_scl_oe, s_sda_oe, ack;
	status_s    st;
	logic [7:0] rbuf;
	int         err_total = 0;
	int         cmp_count = 0;
	row_s       rows [5] = '{
		'{9'h000, 8'ha4, 8'ha5, 8'ha5, 1'b1, 1'b1, 1'b1, 1'b0},
		'{9'h000, 8'ha4, 8'ha4, 8'ha4, 1'b1, 1'b1, 1'b0, 1'b0},
		'{9'h000, 8'ha4, 8'ha6, 8'ha4, 1'b0, 1'b0, 1'b0, 1'b0},
		'{9'h080, 8'h06, 8'hf6, 8'hf6, 1'b1, 1'b1, 1'b0, 1'b1},
		'{9'h080, 8'h04, 8'hf6, 8'hf6, 1'b0, 1'b0, 1'b0, 1'b0}};

	// Open-drain lines with pull-ups: high unless someone pulls low
	assign scl_w = ~(m_scl | s_scl_oe);
	assign sda_w = ~(m_sda | s_sda_oe);

	always #12.5 clk = ~clk;

	i2c_slave_rx #(.FILTER_CYC(1)) dut (.clk_in(clk), .rstn_in(rstn), .scl_in(scl_w),
		.scl_out(), .scl_oe_out(s_scl_oe), .sda_in(sda_w), .sda_out(),
		.sda_oe_out(s_sda_oe), .ctrl_in(ctl), .sw_in(sw), .address_in(adr),
		.status_out(st), .receive_buffer_out(rbuf));

	bus_master m (.clk_in(clk), .scl_in(scl_w), .sda_in(sda_w), .scl_pull_out(m_scl),
		.sda_pull_out(m_sda));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks=%0d mismatches=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Extra edge so the pulse's effect has landed before any check
	task automatic pulse(input logic [4:0] s, input logic [7:0] a);
		@(posedge clk);
		sw <= sw_s'(s);
		adr <= a;
		@(posedge clk);
		sw <= '0;
		@(posedge clk);
	endtask

	task automatic setc(input logic [8:0] v);
		@(posedge clk);
		ctl <= ctrl_s'(v);
	endtask

	initial begin
		int n;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		m.wt(6);
		chk(st, 16'h0042);
		chk({rbuf, s_scl_oe, s_sda_oe}, 16'h0000);
		$display("test reset done");
		foreach (rows[i]) begin
			setc(rows[i].cfg);
			pulse(5'h01, rows[i].a);
			m.start_c();
			m.put_byte(rows[i].b, ack);
			m.wt(8);
			chk(ack, rows[i].ack);
			chk(rbuf, rows[i].bv);
			chk(st.port_irq_flag, rows[i].irq);
			chk(st.read_not_write, rows[i].rnw);
			chk(st.address_refresh_needed, rows[i].refr);
			pulse(5'h1b, rows[i].a);
			chk({st.port_irq_flag, st.address_refresh_needed, st.buffer_full_flag}, 0);
			m.stop_c();
			m.wt(6);
			chk(st.stop_seen, 1'b1);
		end
		$display("test rows done");
		setc(9'h001);
		pulse(5'h01, 8'ha4);
		m.start_c();
		m.put_byte(8'ha4, ack);
		m.wt(8);
		chk({ack, s_scl_oe, st.ack_received_status, st.start_seen}, 4'hd);
		pulse(5'h1a, 8'ha4);
		chk(s_scl_oe, 1'b0);
		m.put_byte(8'h5a, ack);
		m.wt(8);
		chk({ack, rbuf, st.data_not_address}, {1'b1, 8'h5a, 1'b1});
		pulse(5'h12, 8'ha4);
		m.put_byte(8'h3c, ack);
		m.wt(8);
		chk({ack, st.receive_overflow_flag, st.ack_received_status}, 3'b011);
		pulse(5'h1e, 8'ha4);
		m.stop_c();
		$display("test stretch done");
		for (int v = 0; v < 2; v++) begin
			setc(v ? 9'h014 : 9'h010);
			pulse(5'h01, 8'ha4);
			m.start_c();
			fork
				m.put_byte(8'ha4, ack);
				begin
					n = 0;
					while (st.ack_time_status !== 1'b1 && n < 400) begin
						@(posedge clk);
						n++;
					end
					chk(st.ack_time_status, 1'b1);
					pulse(5'h1a, 8'ha4);
				end
			join
			m.wt(8);
			chk(ack, v == 0);
			pulse(5'h1a, 8'ha4);
			m.stop_c();
		end
		$display("test hold done");
		setc(9'h00a);
		pulse(5'h01, 8'ha4);
		m.start_c();
		m.put_byte(8'ha4, ack);
		m.wt(8);
		fork
			m.put_byte(8'h5a, ack);
			begin
				n = 0;
				while (st.ack_time_status !== 1'b1 && n < 400) begin
					@(posedge clk);
					n++;
				end
				chk(st.ack_time_status, 1'b1);
				pulse(5'h02, 8'ha4);
			end
		join
		m.wt(8);
		chk({ack, rbuf, st.receive_overflow_flag}, {1'b1, 8'h5a, 1'b1});
		pulse(5'h1e, 8'ha4);
		m.stop_c();
		$display("test data hold done");
		for (int k = 0; k < 3; k++) begin
			setc(k == 0 ? 9'h100 : (k == 1 ? 9'h060 : 9'h000));
			m.start_c();
			m.wt(8);
			chk(st.port_irq_flag, k < 2);
			pulse(5'h10, 8'ha4);
			m.stop_c();
			m.wt(6);
			chk({st.port_irq_flag, st.stop_seen}, {k < 2, 1'b1});
			pulse(5'h10, 8'ha4);
		end
		$display("test condition irq done");
		for (int k = 0; k < 2; k++) begin
			setc(9'h080);
			pulse(5'h01, 8'h06);
			m.start_c();
			m.put_byte(8'hf6, ack);
			m.wt(8);
			chk({ack, st.address_refresh_needed, s_scl_oe}, 3'b111);
			pulse(5'h19, 8'h3c);
			m.put_byte(k ? 8'h3d : 8'h3c, ack);
			m.wt(8);
			chk({ack, st.port_irq_flag, st.address_refresh_needed}, {k == 0, 2'b11});
			pulse(5'h1b, 8'h06);
			m.stop_c();
		end
		$display("test ten bit done");
		chk(m.stuck, 0);
		results();
	end

	// Whole run needs well under a millisecond
	initial begin
		#2000000;
		err_total++;
		results();
	end
endmodule
